/* rcsi_pkg.sv */
// reset cause and state init package: register map, field positions, reset values
// assumes a 32-bit apb slave with one aligned word per register
package rcsi_pkg;
	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [11:0] RCSI_IDX_STATUS = 12'h003;
	localparam logic [11:0] RCSI_IDX_PWRCTL = 12'h08e;
	localparam logic [11:0] RCSI_IDX_IRQSTS = 12'h090;
	localparam logic [11:0] RCSI_IDX_IRQMSK = 12'h091;
	localparam logic [11:0] RCSI_ADDR_STATUS = 12'(RCSI_IDX_STATUS * 4);
	localparam logic [11:0] RCSI_ADDR_PWRCTL = 12'(RCSI_IDX_PWRCTL * 4);
	localparam logic [11:0] RCSI_ADDR_IRQSTS = 12'(RCSI_IDX_IRQSTS * 4);
	localparam logic [11:0] RCSI_ADDR_IRQMSK = 12'(RCSI_IDX_IRQMSK * 4);
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RCSI_ST_TIMEOUT = 4;
	localparam int RCSI_ST_PWRDN = 3;
	localparam int RCSI_PC_BROWN = 0;
	localparam int RCSI_PC_POR = 1;
	localparam int RCSI_PC_SPEED = 3;
	localparam int RCSI_EV_BROWN = 0;
	localparam int RCSI_EV_MCLEAR = 1;
	localparam int RCSI_EV_WDOG = 2;
	localparam int RCSI_EV_WDOGWAKE = 3;
	localparam int RCSI_EV_IRQWAKE = 4;
	localparam int RCSI_EV_W = 5;
	// ----------------------------------------
	// masks and reset values
	// ----------------------------------------
	localparam logic [7:0] RCSI_PWRCTL_MASK = 8'h0b;
	localparam logic [7:0] RCSI_STATUS_POR = 8'h18;
	localparam logic [2:0] RCSI_BANK_RST = 3'h0;
	localparam logic [2:0] RCSI_ALU_POR = 3'h0;
	localparam logic [4:0] RCSI_EV_RST = 5'h00;
	localparam int RCSI_PC_W = 13;
	localparam logic [RCSI_PC_W-1:0] RCSI_PC_RESET = 13'h0000;
	localparam logic [RCSI_PC_W-1:0] RCSI_PC_VECTOR = 13'h0004;
	localparam logic [RCSI_PC_W-1:0] RCSI_PC_STEP = 13'h0001;
	// ----------------------------------------
	// reset causes and states
	// ----------------------------------------
	typedef enum logic [3:0] {
		RCSI_CAUSE_NONE = 4'b0001,
		RCSI_CAUSE_BROWN = 4'b0010,
		RCSI_CAUSE_MCLEAR = 4'b0100,
		RCSI_CAUSE_WDOG = 4'b1000
	} rcsi_cause_t;
	typedef enum logic [1:0] {
		RCSI_ST_RUN = 2'b01,
		RCSI_ST_HOLD = 2'b10
	} rcsi_state_t;
endpackage

/* rcsi_top.sv */
// reset cause recorder and special register initialiser with apb register access
// assumes reset sources and core status are synchronous to ref_clk; rst_n is power-on
`timescale 1ns/1ps
module rcsi_top
	import rcsi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic brownoutDet,
	input wire logic masterClearPinN,
	input wire logic watchdogTimeout,
	input wire logic irqWake,
	input wire logic sleeping,
	input wire logic globalIrqEnable,
	input wire logic instrDone,
	input wire logic [12:0] pcCurrent,
	output logic coreRstN,
	output logic wakeResume,
	output logic pcLoad,
	output logic [12:0] pcValue,
	output logic oscSpeedSelect,
	output logic irqOut
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	rcsi_state_t state_q;
	rcsi_cause_t cause_q;
	logic heldInSleep_q;
	logic timeOutFlag_q;
	logic powerDownFlag_q;
	logic powerOnFlag_q;
	logic brownoutFlag_q;
	logic oscSpeedSelect_q;
	logic [2:0] bankBits_q;
	logic [2:0] aluBits_q;
	logic vectorArm_q;
	logic wakeResume_q;
	logic pcLoad_q;
	logic [12:0] pcValue_q;
	wire logic [4:0] irqStatus_q;
	logic [4:0] irqMask_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic resetReq;
	logic wdtWake;
	logic intWake;
	logic release_;
	logic setupPh;
	logic wrAcc;
	logic wrStatus;
	logic wrPwrCtl;
	logic wrIrqSts;
	logic wrIrqMsk;
	logic mapped;
	logic [4:0] events;
	rcsi_cause_t newCause;
	assign resetReq = brownoutDet | ~masterClearPinN | (watchdogTimeout & ~sleeping);
	assign wdtWake = (state_q == RCSI_ST_RUN) & sleeping & watchdogTimeout & ~resetReq;
	assign intWake = (state_q == RCSI_ST_RUN) & sleeping & irqWake & ~resetReq & ~wdtWake;
	assign release_ = (state_q == RCSI_ST_HOLD) & ~brownoutDet & masterClearPinN;
	assign setupPh = psel & ~penable;
	assign wrAcc = psel & penable & pwrite & pstrb[0];
	assign wrStatus = wrAcc & (paddr == RCSI_ADDR_STATUS);
	assign wrPwrCtl = wrAcc & (paddr == RCSI_ADDR_PWRCTL);
	assign wrIrqSts = wrAcc & (paddr == RCSI_ADDR_IRQSTS);
	assign wrIrqMsk = wrAcc & (paddr == RCSI_ADDR_IRQMSK);
	assign mapped = (paddr == RCSI_ADDR_STATUS) | (paddr == RCSI_ADDR_PWRCTL) |
		(paddr == RCSI_ADDR_IRQSTS) | (paddr == RCSI_ADDR_IRQMSK);
	// one cause, brown-out before master clear before watchdog
	always_comb begin
		if (brownoutDet) begin
			newCause = RCSI_CAUSE_BROWN;
		end else if (!masterClearPinN) begin
			newCause = RCSI_CAUSE_MCLEAR;
		end else if (watchdogTimeout) begin
			newCause = RCSI_CAUSE_WDOG;
		end else begin
			newCause = RCSI_CAUSE_NONE;
		end
	end
	// ----------------------------------------
	// reset sequencing
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= RCSI_ST_RUN;
			cause_q <= RCSI_CAUSE_NONE;
			heldInSleep_q <= 1'b0;
		end else begin
			case (state_q)
				RCSI_ST_RUN: begin
					if (resetReq) begin
						state_q <= RCSI_ST_HOLD;
						cause_q <= newCause;
						heldInSleep_q <= sleeping;
					end
				end
				RCSI_ST_HOLD: begin
					// brown-out during hold takes over the cause
					if (brownoutDet) begin
						cause_q <= RCSI_CAUSE_BROWN;
					end
					if (release_) begin
						state_q <= RCSI_ST_RUN;
					end
				end
				default: begin
					state_q <= RCSI_ST_RUN;
				end
			endcase
		end
	end
	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timeOutFlag_q <= 1'b1;
			powerDownFlag_q <= 1'b1;
			bankBits_q <= RCSI_BANK_RST;
			aluBits_q <= RCSI_ALU_POR;
		end else if (release_) begin
			bankBits_q <= RCSI_BANK_RST;
			case (cause_q)
				RCSI_CAUSE_BROWN: begin
					timeOutFlag_q <= 1'b1;
					powerDownFlag_q <= 1'b1;
				end
				RCSI_CAUSE_MCLEAR: begin
					if (heldInSleep_q) begin
						timeOutFlag_q <= 1'b1;
						powerDownFlag_q <= 1'b0;
					end
				end
				RCSI_CAUSE_WDOG: begin
					timeOutFlag_q <= 1'b0;
				end
				default: begin
					timeOutFlag_q <= timeOutFlag_q;
				end
			endcase
		end else if (wdtWake) begin
			timeOutFlag_q <= 1'b0;
			powerDownFlag_q <= 1'b0;
		end else if (intWake) begin
			timeOutFlag_q <= 1'b1;
			powerDownFlag_q <= 1'b0;
		end else if (wrStatus) begin
			bankBits_q <= pwdata[7:5];
			aluBits_q <= pwdata[2:0];
		end
	end
	// ----------------------------------------
	// power control flags
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			powerOnFlag_q <= 1'b0;
			brownoutFlag_q <= 1'b0;
			oscSpeedSelect_q <= 1'b1;
		end else if (release_) begin
			oscSpeedSelect_q <= 1'b1;
			if (cause_q == RCSI_CAUSE_BROWN) begin
				brownoutFlag_q <= 1'b0;
			end
		end else if (wrPwrCtl) begin
			powerOnFlag_q <= pwdata[RCSI_PC_POR];
			brownoutFlag_q <= pwdata[RCSI_PC_BROWN];
			oscSpeedSelect_q <= pwdata[RCSI_PC_SPEED];
		end
	end
	// ----------------------------------------
	// program counter control
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pcLoad_q <= 1'b1;
			pcValue_q <= RCSI_PC_RESET;
			wakeResume_q <= 1'b0;
			vectorArm_q <= 1'b0;
		end else begin
			pcLoad_q <= 1'b0;
			wakeResume_q <= 1'b0;
			if (resetReq || state_q == RCSI_ST_HOLD) begin
				vectorArm_q <= 1'b0;
			end
			if (release_) begin
				pcLoad_q <= 1'b1;
				pcValue_q <= RCSI_PC_RESET;
			end else if (wdtWake || intWake) begin
				pcLoad_q <= 1'b1;
				pcValue_q <= 13'(pcCurrent + RCSI_PC_STEP);
				wakeResume_q <= 1'b1;
				vectorArm_q <= intWake & globalIrqEnable;
			end else if (vectorArm_q && instrDone) begin
				pcLoad_q <= 1'b1;
				pcValue_q <= RCSI_PC_VECTOR;
				vectorArm_q <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// event interrupts
	// ----------------------------------------
	always_comb begin
		events = RCSI_EV_RST;
		events[RCSI_EV_BROWN] = release_ & (cause_q == RCSI_CAUSE_BROWN);
		events[RCSI_EV_MCLEAR] = release_ & (cause_q == RCSI_CAUSE_MCLEAR);
		events[RCSI_EV_WDOG] = release_ & (cause_q == RCSI_CAUSE_WDOG);
		events[RCSI_EV_WDOGWAKE] = wdtWake;
		events[RCSI_EV_IRQWAKE] = intWake;
	end
	// one sticky bit per event
	for (genvar i = 0; i < RCSI_EV_W; i++) begin : g_sticky
		rcsi_sticky_bit #(
			.RESET_VAL(RCSI_EV_RST[i])
		) u_rcsi_sticky_bit (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.setEv(events[i]),
			.clrReq(wrIrqSts & pwdata[i]),
			.bitOut(irqStatus_q[i])
		);
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irqMask_q <= RCSI_EV_RST;
		end else if (wrIrqMsk) begin
			irqMask_q <= pwdata[4:0];
		end
	end
	// ----------------------------------------
	// apb read path
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (setupPh) begin
			pslverr_q <= ~mapped;
			case (paddr)
				RCSI_ADDR_STATUS: begin
					prdata_q <= {24'h000000, bankBits_q, timeOutFlag_q, powerDownFlag_q, aluBits_q};
				end
				RCSI_ADDR_PWRCTL: begin
					// unimplemented bits stay zero
					prdata_q <= {24'h000000, 4'h0, oscSpeedSelect_q, 1'b0, powerOnFlag_q,
						brownoutFlag_q} & {24'h000000, RCSI_PWRCTL_MASK};
				end
				RCSI_ADDR_IRQSTS: begin
					prdata_q <= {27'h0000000, irqStatus_q};
				end
				RCSI_ADDR_IRQMSK: begin
					prdata_q <= {27'h0000000, irqMask_q};
				end
				default: begin
					prdata_q <= 32'h00000000;
				end
			endcase
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pready = psel & penable;
	assign prdata = prdata_q;
	assign pslverr = psel & penable & pslverr_q;
	assign coreRstN = rst_n & (state_q == RCSI_ST_RUN);
	assign wakeResume = wakeResume_q;
	assign pcLoad = pcLoad_q;
	assign pcValue = pcValue_q;
	assign oscSpeedSelect = oscSpeedSelect_q;
	assign irqOut = |(irqStatus_q & irqMask_q);
endmodule

// ----------------------------------------
// sticky event bit, set wins over clear
// ----------------------------------------
module rcsi_sticky_bit
#(
	parameter logic RESET_VAL = 1'b0
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic setEv,
	input wire logic clrReq,
	output logic bitOut
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic bit_q;
	logic bit_d;
	// ----------------------------------------
	// next value and register
	// ----------------------------------------
	always_comb begin
		// a clear in the cycle of a new event must not lose it
		bit_d = bit_q & ~clrReq;
		if (setEv) begin
			bit_d = 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bit_q <= RESET_VAL;
		end else begin
			bit_q <= bit_d;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bitOut = bit_q;
endmodule

/* rcsi_chk.sv */
// assertion checker for the reset cause and state init block
// assumes it is bound to rcsi_top and sees only its ports
`timescale 1ns/1ps
module rcsi_chk
	import rcsi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic brownoutDet,
	input wire logic masterClearPinN,
	input wire logic watchdogTimeout,
	input wire logic irqWake,
	input wire logic sleeping,
	input wire logic globalIrqEnable,
	input wire logic instrDone,
	input wire logic [12:0] pcCurrent,
	input wire logic coreRstN,
	input wire logic wakeResume,
	input wire logic pcLoad,
	input wire logic [12:0] pcValue
);
	// ---
	// helpers and properties
	// ---
	logic vecPend_q;
	wire quiet = !brownoutDet && masterClearPinN && coreRstN && sleeping;
	wire irqWk = quiet && irqWake && !watchdogTimeout;
	wire mapped = paddr == RCSI_ADDR_STATUS || paddr == RCSI_ADDR_PWRCTL
		|| paddr == RCSI_ADDR_IRQSTS || paddr == RCSI_ADDR_IRQMSK;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			vecPend_q <= 1'b0;
		else if (irqWk && globalIrqEnable)
			vecPend_q <= 1'b1;
		else if (instrDone || !coreRstN)
			vecPend_q <= 1'b0;
	end
	ready_ok_a: assert property (psel && penable |-> pready)
		else $error("pready missing in access");
	err_flag_a: assert property (psel && !penable && !mapped ##1 psel && penable |-> pslverr)
		else $error("no error on unmapped address");
	rel_pc_a: assert property ($rose(coreRstN) |-> pcLoad && pcValue == RCSI_PC_RESET)
		else $error("no pc zero load at reset release");
	src_hold_a: assert property (coreRstN && (brownoutDet || !masterClearPinN) |=> !coreRstN)
		else $error("reset source not taken");
	wdt_hold_a: assert property (coreRstN && watchdogTimeout && !sleeping |=> !coreRstN)
		else $error("running watchdog did not reset");
	bo_stay_a: assert property (!coreRstN && brownoutDet |=> !coreRstN)
		else $error("released during brown-out");
	irq_wake_a: assert property (irqWk |=> wakeResume && pcLoad
		&& pcValue == 13'($past(pcCurrent) + RCSI_PC_STEP))
		else $error("interrupt wake pc wrong");
	wdt_wake_a: assert property (quiet && watchdogTimeout |=> wakeResume
		&& pcValue == 13'($past(pcCurrent) + RCSI_PC_STEP))
		else $error("watchdog wake pc wrong");
	vec_jump_a: assert property (vecPend_q && instrDone |=> pcLoad && pcValue == RCSI_PC_VECTOR)
		else $error("no branch to vector");
	pwr_zero_a: assert property (psel && !penable && !pwrite && paddr == RCSI_ADDR_PWRCTL
		##1 penable |-> prdata[31:4] == 28'h0 && !prdata[2])
		else $error("unimplemented bits not zero");
	cover property ($rose(wakeResume));
	cover property ($fell(coreRstN));
	cover property (pslverr);
endmodule
bind rcsi_top rcsi_chk u_chk(.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .brownoutDet, .masterClearPinN, .watchdogTimeout, .irqWake, .sleeping,
	.globalIrqEnable, .instrDone, .pcCurrent, .coreRstN, .wakeResume, .pcLoad, .pcValue);

/* rcsi_top_test.sv */
// self-checking bench for the reset cause and state init block
// assumes rcsi_top and the bound checker are compiled before it
`timescale 1ns/1ps
module rcsi_top_test
	import rcsi_pkg::*;
;
	// ---
	// stimulus, tasks and tests
	// ---
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, brownoutDet = 0;
	logic masterClearPinN = 1, watchdogTimeout = 0, irqWake = 0, sleeping = 0;
	logic globalIrqEnable = 0, instrDone = 0, pready, pslverr, coreRstN, wakeResume;
	logic pcLoad, oscSpeedSelect, irqOut, rerr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0] pstrb = 4'hf;
	logic [12:0] pcCurrent = 13'h0000, pcValue;
	int bad_count = 0, n_checks = 0;
	rcsi_top u_rcsi_top(.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .brownoutDet, .masterClearPinN, .watchdogTimeout,
		.irqWake, .sleeping, .globalIrqEnable, .instrDone, .pcCurrent, .coreRstN,
		.wakeResume, .pcLoad, .pcValue, .oscSpeedSelect, .irqOut);
	initial forever #10 ref_clk = ~ref_clk;
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task rst_src(input logic bo, mc, wd, sl);
		@(posedge ref_clk);
		sleeping <= sl;
		brownoutDet <= bo;
		masterClearPinN <= !mc;
		watchdogTimeout <= wd;
		@(posedge ref_clk);
		brownoutDet <= 1'b0;
		masterClearPinN <= 1'b1;
		watchdogTimeout <= 1'b0;
		#1;
		while (coreRstN !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		chk("pc reload", 32'h2000, {18'h0, pcLoad, pcValue});
		@(posedge ref_clk);
		sleeping <= 1'b0;
	endtask
	task wake(input logic wd, global_irq_enable, input logic [12:0] pc);
		@(posedge ref_clk);
		sleeping <= 1'b1;
		globalIrqEnable <= global_irq_enable;
		pcCurrent <= pc;
		watchdogTimeout <= wd;
		irqWake <= !wd;
		@(posedge ref_clk);
		watchdogTimeout <= 1'b0;
		irqWake <= 1'b0;
		#1;
		chk("wake pc", {17'h0, 2'b11, 13'(pc + 13'h1)}, {17'h0, wakeResume, pcLoad, pcValue});
		@(posedge ref_clk);
		sleeping <= 1'b0;
		instrDone <= global_irq_enable;
		@(posedge ref_clk);
		instrDone <= 1'b0;
		globalIrqEnable <= 1'b0;
		#1;
		if (global_irq_enable) chk("vector", 32'h2004, {18'h0, pcLoad, pcValue});
	endtask
	task t_regs;
		rd("status por", RCSI_ADDR_STATUS, 32'h18);
		rd("pwrctl por", RCSI_ADDR_PWRCTL, 32'h08);
		apb(1'b1, RCSI_ADDR_STATUS, 32'hffffffff);
		apb(1'b1, RCSI_ADDR_PWRCTL, 32'hffffffff);
		rd("status rw", RCSI_ADDR_STATUS, 32'hff);
		rd("pwrctl rw", RCSI_ADDR_PWRCTL, 32'h0b);
		apb(1'b1, RCSI_ADDR_PWRCTL, 32'h03);
		#1;
		chk("osc speed", 32'h0, {31'h0, oscSpeedSelect});
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rerr});
		$display("test regs done");
	endtask
	task t_wakes;
		rst_src(1'b0, 1'b1, 1'b0, 1'b0);
		rd("status master_clear_pin", RCSI_ADDR_STATUS, 32'h1f);
		rd("pwrctl master_clear_pin", RCSI_ADDR_PWRCTL, 32'h0b);
		chk("osc speed reset", 32'h1, {31'h0, oscSpeedSelect});
		wake(1'b0, 1'b1, 13'h1fff);
		rd("status irq wake", RCSI_ADDR_STATUS, 32'h17);
		wake(1'b1, 1'b0, 13'h0100);
		rd("status wdt wake", RCSI_ADDR_STATUS, 32'h07);
		rst_src(1'b0, 1'b1, 1'b0, 1'b1);
		rd("status master_clear_pin sleep", RCSI_ADDR_STATUS, 32'h17);
		rst_src(1'b0, 1'b0, 1'b1, 1'b0);
		rd("status wdt", RCSI_ADDR_STATUS, 32'h07);
		$display("test wakes done");
	endtask
	task t_irq;
		rd("irq status", RCSI_ADDR_IRQSTS, 32'h1e);
		chk("irq masked", 32'h0, {31'h0, irqOut});
		apb(1'b1, RCSI_ADDR_IRQMSK, 32'h04);
		#1;
		chk("irq raised", 32'h1, {31'h0, irqOut});
		apb(1'b1, RCSI_ADDR_IRQSTS, 32'h1f);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irqOut});
		rst_src(1'b1, 1'b1, 1'b0, 1'b0);
		rd("status bor", RCSI_ADDR_STATUS, 32'h1f);
		rd("pwrctl bor", RCSI_ADDR_PWRCTL, 32'h0a);
		rd("one cause", RCSI_ADDR_IRQSTS, 32'h01);
		$display("test irq done");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_wakes();
		t_irq();
		close_out();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		bad_count++;
		close_out();
	end
endmodule
